// >>> cycle_bridge_defs.svh
// Purpose: constants of the processor to expansion-bus cycle bridge
// Assumes: core_clk is the doubled-rate oscillator, 100 MHz
// Notes:   definitions only
`ifndef CYCLE_BRIDGE_DEFS_SVH
`define CYCLE_BRIDGE_DEFS_SVH

// ==========================================================
// register map
`define BTC_IO_ADDR        16'hFC80
`define BTC_RESET          8'h00
`define BTC_MODE_SEL_BIT   2
`define BTC_WAIT16_LSB     3
`define BTC_WAIT8_LSB      5

// ==========================================================
// timing
`define OSC_PERIOD_NS      10
`define TSTATE_OSC_CYCLES  4
`define WAIT8_BASE         3'h2
`define PHASE_START        2'h0
`define PHASE_SECOND       2'h2
`define PHASE_LAST         2'h3

`endif

// >>> cycle_bridge_pkg.sv
// Purpose: types shared by the cycle bridge modules
// Assumes: constants live in cycle_bridge_defs.svh
// Notes:   none
package cycle_bridge_pkg;

  // ==========================================================
  // sequencer states
  typedef enum logic [2:0] {
    st_idle,
    st_status,
    st_command,
    st_wait,
    st_register
  } seq_state_type;

  // ==========================================================
  // complete sequencer state
  typedef struct packed {
    seq_state_type state;
    logic          mem;
    logic          wr;
    logic          odd;
    logic          sixteen;
    logic          cs16;
    logic          second;
    logic          zws;
    logic [2:0]    waits;
    logic [7:0]    hold;
    logic [7:0]    ctrl;
    logic [7:0]    lo_out;
    logic [6:0]    la;
  } seq_regs_type;

  typedef struct packed {
    logic [1:0] cnt;
  } div_regs_type;

endpackage

// >>> tstate_if.sv
// Purpose: carries the T-state phase from the divider to the sequencer
// Assumes: one phase step per rising core_clk edge
// Notes:   none
interface tstate_if;
  logic [1:0] phase;
  modport divider (output phase);
  modport sequencer (input phase);
endinterface

// >>> clock_phase_divider.sv
// Purpose: derives processor and bus clocks and the T-state phase
// Assumes: core_clk is the doubled-rate oscillator
// Notes:   only the slow synchronous ratio is built
`include "cycle_bridge_defs.svh"

module clock_phase_divider (
  input  wire logic core_clk,
  input  wire logic reset_n,
  tstate_if.divider tp,
  output logic      processor_clock_out,
  output logic      expansion_bus_clock
);

  cycle_bridge_pkg::div_regs_type r_q;
  cycle_bridge_pkg::div_regs_type r_d;

  // ==========================================================
  // divider
  always_comb begin
    r_d     = r_q;
    r_d.cnt = r_q.cnt + 2'h1;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign processor_clock_out = r_q.cnt[0];
  assign expansion_bus_clock = r_q.cnt[1];
  assign tp.phase            = r_q.cnt;

  // ==========================================================
  // checks
  a_proc_clk_half: assert property (@(posedge core_clk) disable iff (!reset_n)
    processor_clock_out |=> !processor_clock_out ##1 processor_clock_out)
    else $error("processor clock is not oscillator divided by two");

  a_bus_clk_quarter: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(expansion_bus_clock) |-> expansion_bus_clock [*2] ##1 !expansion_bus_clock [*2])
    else $error("bus clock is not oscillator divided by four");

endmodule // clock_phase_divider

// >>> cpu_expansion_bus_cycle_bridge.sv
// Purpose: runs processor cycles onto the expansion bus in slow synchronous mode
// Assumes: processor status and inputs are synchronous to core_clk
// Notes:   other clock modes are not built; a set mode select bit is only reported
`include "cycle_bridge_defs.svh"

module cpu_expansion_bus_cycle_bridge (
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic [23:0] cpu_addr,
  input  wire logic        cpu_mem_io,
  input  wire logic        cpu_s0_n,
  input  wire logic        cpu_s1_n,
  input  wire logic        byte_high_enable_n,
  input  wire logic [7:0]  cpu_lo_data_in,
  input  wire logic [7:0]  exp_lo_data_in,
  input  wire logic        memcs16_n,
  input  wire logic        iocs16_n,
  input  wire logic        zero_ws_n,
  input  wire logic        io_ch_rdy,
  output logic             processor_clock_out,
  output logic             expansion_bus_clock,
  output logic             sys_addr_latch_strobe,
  output logic             bus_addr_latch_enable,
  output logic             fast_upper_addr_latch,
  output logic [6:0]       local_upper_addr,
  output logic             sys_addr_bit0,
  output logic             low_lane_buf_en_n,
  output logic             high_lane_buf_en_n,
  output logic             byte_swap_buf_en_n,
  output logic             data_xmit_recv_dir,
  output logic [7:0]       cpu_lo_data_out,
  output logic             cpu_lo_data_oe_n,
  output logic             mem_read_n,
  output logic             mem_write_n,
  output logic             io_read_n,
  output logic             io_write_n,
  output logic             cpu_ready_n,
  output logic             bus_command_state,
  output logic             slow_mode_active
);

  tstate_if tp ();

  clock_phase_divider u_div (
    .core_clk            (core_clk),
    .reset_n             (reset_n),
    .tp                  (tp),
    .processor_clock_out (processor_clock_out),
    .expansion_bus_clock (expansion_bus_clock)
  );

  cycle_bridge_pkg::seq_regs_type r_q;
  cycle_bridge_pkg::seq_regs_type r_d;

  logic [1:0] ph;
  logic       ph_late;
  logic       st_req;
  logic       in_status;
  logic       in_cmd_state;
  logic       in_wait;
  logic       in_data;
  logic       wide;
  logic       conv;
  logic       hi_path;
  logic       fast16;
  logic       cmd_on;
  logic       finish;
  logic       final_byte;
  logic [2:0] prog_waits;

  // ==========================================================
  // decode helpers
  assign ph           = tp.phase;
  assign ph_late      = ph[1];
  assign st_req       = !(cpu_s0_n && cpu_s1_n);
  assign in_status    = r_q.state == cycle_bridge_pkg::st_status;
  assign in_cmd_state = r_q.state == cycle_bridge_pkg::st_command;
  assign in_wait      = r_q.state == cycle_bridge_pkg::st_wait;
  assign wide         = r_q.sixteen && r_q.cs16;
  assign conv         = r_q.sixteen && !r_q.cs16;
  assign hi_path      = (!r_q.sixteen && r_q.odd) || (conv && r_q.second);
  assign final_byte   = !conv || r_q.second;

  // 16-bit memory select is looked at before the registered copy exists
  assign fast16 = r_q.mem && r_q.sixteen && !r_q.second
                  && ((ph == `PHASE_START) ? !memcs16_n : r_q.cs16);

  always_comb begin
    if (r_q.sixteen && r_q.cs16) begin
      prog_waits = {1'b0, r_q.ctrl[`BTC_WAIT16_LSB +: 2]};
    end else begin
      prog_waits = `WAIT8_BASE + {1'b0, r_q.ctrl[`BTC_WAIT8_LSB +: 2]};
    end
  end

  // zero-wait beats both programmed waits and channel ready
  always_comb begin
    if (in_cmd_state) begin
      finish = r_q.zws || (prog_waits == 3'h0 && io_ch_rdy);
    end else begin
      finish = r_q.zws || (r_q.waits <= 3'h1 && io_ch_rdy);
    end
  end

  // ==========================================================
  // sequencer
  always_comb begin
    r_d = r_q;
    if (fast_upper_addr_latch) begin
      r_d.la = r_q.la;
    end else begin
      r_d.la = cpu_addr[23:17];
    end
    case (r_q.state)
      cycle_bridge_pkg::st_idle: begin
        if (ph == `PHASE_START && st_req) begin
          r_d.state  = cycle_bridge_pkg::st_status;
          r_d.second = 1'b0;
        end
      end
      cycle_bridge_pkg::st_status: begin
        if (ph == `PHASE_SECOND && !r_q.second) begin
          r_d.mem     = cpu_mem_io;
          r_d.wr      = cpu_s1_n && !cpu_s0_n;
          r_d.odd     = cpu_addr[0];
          r_d.sixteen = !cpu_addr[0] && !byte_high_enable_n;
          r_d.cs16    = 1'b0;
        end
        if (ph == `PHASE_LAST) begin
          r_d.zws = 1'b0;
          if (!r_q.mem && cpu_addr[15:0] == `BTC_IO_ADDR) begin
            r_d.state  = cycle_bridge_pkg::st_register;
            r_d.lo_out = r_q.ctrl;
          end else begin
            r_d.state = cycle_bridge_pkg::st_command;
          end
        end
      end
      cycle_bridge_pkg::st_command, cycle_bridge_pkg::st_wait: begin
        if (ph == `PHASE_START && in_cmd_state && r_q.mem && !r_q.second) begin
          r_d.cs16 = r_q.sixteen && !memcs16_n;
        end
        if (ph == `PHASE_SECOND) begin
          if (in_cmd_state && !r_q.mem && !r_q.second) begin
            r_d.cs16 = r_q.sixteen && !iocs16_n;
          end
          r_d.zws = !zero_ws_n;
        end
        if (ph == `PHASE_LAST) begin
          if (finish) begin
            r_d.zws = 1'b0;
            if (final_byte) begin
              r_d.state = cycle_bridge_pkg::st_idle;
            end else begin
              r_d.state  = cycle_bridge_pkg::st_status;
              r_d.second = 1'b1;
              if (!r_q.wr) begin
                r_d.hold   = exp_lo_data_in;
                r_d.lo_out = exp_lo_data_in;
              end
            end
          end else if (in_cmd_state) begin
            r_d.state = cycle_bridge_pkg::st_wait;
            r_d.waits = prog_waits;
          end else if (r_q.waits != 3'h0) begin
            r_d.waits = r_q.waits - 3'h1;
          end
        end
      end
      cycle_bridge_pkg::st_register: begin
        if (ph == `PHASE_SECOND && r_q.wr) begin
          r_d.ctrl = cpu_lo_data_in;
        end
        if (ph == `PHASE_LAST) begin
          r_d.state = cycle_bridge_pkg::st_idle;
        end
      end
      default: begin
        r_d.state = cycle_bridge_pkg::st_idle;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      r_q       <= '0;
      r_q.state <= cycle_bridge_pkg::st_idle;
      r_q.ctrl  <= `BTC_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  // ==========================================================
  // address strobes
  assign sys_addr_latch_strobe = in_status && ph_late;
  assign bus_addr_latch_enable = in_status && ph_late;
  assign fast_upper_addr_latch = (in_status && ph_late) || (in_cmd_state && !ph_late);
  assign local_upper_addr      = r_q.la;
  assign sys_addr_bit0         = r_q.second ? 1'b1 : cpu_addr[0];
  assign bus_command_state     = in_cmd_state;

  // ==========================================================
  // commands; the half-state delay buys address setup for slow boards
  assign cmd_on      = in_wait || (in_cmd_state && (ph_late || fast16));
  assign mem_read_n  = !(cmd_on && r_q.mem && !r_q.wr);
  assign mem_write_n = !(cmd_on && r_q.mem && r_q.wr);
  assign io_read_n   = !(cmd_on && !r_q.mem && !r_q.wr);
  assign io_write_n  = !(cmd_on && !r_q.mem && r_q.wr);
  assign cpu_ready_n = !((in_cmd_state || in_wait) && ph == `PHASE_LAST
                         && finish && final_byte)
                       && !(r_q.state == cycle_bridge_pkg::st_register && ph == `PHASE_LAST);

  // ==========================================================
  // data lanes; low lane is off whenever the swap path is on to avoid contention
  assign in_data            = in_wait || (in_cmd_state && ph != `PHASE_START);
  assign low_lane_buf_en_n  = !(in_data && !hi_path);
  assign high_lane_buf_en_n = !(in_data && (wide || hi_path));
  assign byte_swap_buf_en_n = !(in_data && hi_path);
  assign data_xmit_recv_dir = r_q.wr;
  assign cpu_lo_data_out    = r_q.lo_out;
  assign cpu_lo_data_oe_n   = !((in_data && conv && r_q.second && !r_q.wr)
                                || (r_q.state == cycle_bridge_pkg::st_register && !r_q.wr));
  assign slow_mode_active   = !r_q.ctrl[`BTC_MODE_SEL_BIT];

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_sys_addr_latch_strobe_two_cycles: assert property (
    $rose(sys_addr_latch_strobe) |-> sys_addr_latch_strobe [*2] ##1 !sys_addr_latch_strobe)
    else $error("system latch strobe not two cycles wide");

  a_fast_upper_addr_latch_span: assert property (
    $rose(fast_upper_addr_latch) ##1 fast_upper_addr_latch ##1 in_cmd_state
      |-> fast_upper_addr_latch [*2] ##1 !fast_upper_addr_latch)
    else $error("fast latch strobe span wrong");

  a_la_held: assert property (
    fast_upper_addr_latch && $past(fast_upper_addr_latch) |-> $stable(local_upper_addr))
    else $error("upper address moved while latched");

  a_swap_low_off: assert property (
    !byte_swap_buf_en_n |-> low_lane_buf_en_n && !high_lane_buf_en_n)
    else $error("swap path with wrong lane enables");

  a_conv_first_half: assert property (
    in_data && conv && !r_q.second |-> !low_lane_buf_en_n && high_lane_buf_en_n
      && byte_swap_buf_en_n)
    else $error("first converted byte not on low lane");

  a_io_cmd_delay: assert property (
    $fell(io_read_n) || $fell(io_write_n) |-> ph == `PHASE_SECOND)
    else $error("io command not delayed to mid state");

  a_mem16_early: assert property (
    in_cmd_state && ph == `PHASE_START && r_q.mem && r_q.sixteen && !r_q.second
      && !memcs16_n |-> !(mem_read_n && mem_write_n))
    else $error("16-bit memory command late");

  a_zws_ends: assert property (
    (in_cmd_state || in_wait) && ph == `PHASE_SECOND && !zero_ws_n
      |-> ##2 mem_read_n && mem_write_n && io_read_n && io_write_n)
    else $error("zero wait did not end the state");

  a_ready_last: assert property (
    !cpu_ready_n && r_q.state != cycle_bridge_pkg::st_register |-> final_byte ##1 !cmd_on)
    else $error("ready before the last byte");

  a_rdy_bound: assert property (
    in_wait && r_q.waits <= 3'h1 && $rose(io_ch_rdy) |-> ##[1:8] !in_wait)
    else $error("cycle not completed after channel ready");

  a_second_odd: assert property (
    in_data && conv && r_q.second |-> sys_addr_bit0)
    else $error("second byte address not odd");

endmodule // cpu_expansion_bus_cycle_bridge

// >>> expansion_board_model.sv
// Purpose: expansion board facing the bridge's command strobes
// Assumes: strobes change just after core_clk edges
// Notes:   a released data lane toggles instead of keeping the last byte
module expansion_board_model (
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       mem_read_n,
  input  wire logic       mem_write_n,
  input  wire logic       io_read_n,
  input  wire logic       io_write_n,
  input  wire logic       sys_addr_bit0,
  input  wire logic       board16,
  input  wire logic       zws_req,
  input  wire logic [7:0] stall,
  output logic      [7:0] exp_lo_data_in,
  output logic            memcs16_n,
  output logic            iocs16_n,
  output logic            zero_ws_n,
  output logic            io_ch_rdy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       cmd;
  logic       cmd_q;
  logic [7:0] left_q;
  logic [7:0] last_q;
  // ====================================================
  // board answers
  assign cmd = !(mem_read_n && mem_write_n && io_read_n && io_write_n);
  assign memcs16_n = !board16;
  assign iocs16_n = !board16;
  assign zero_ws_n = !zws_req;
  // pulled low one core_clk after the strobe starts, well before the last wait ends
  assign io_ch_rdy = (left_q == 8'h00);
  assign exp_lo_data_in = (!mem_read_n || !io_read_n) ?
                          (sys_addr_bit0 ? 8'hB7 : 8'h4C) : ~last_q;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_q <= 1'b0;
      left_q <= 8'h00;
      last_q <= 8'h00;
    end else begin
      cmd_q <= cmd;
      last_q <= exp_lo_data_in;
      if (cmd && !cmd_q) begin
        left_q <= stall;
      end else if (left_q != 8'h00) begin
        left_q <= left_q - 8'h01;
      end
    end
  end
endmodule // expansion_board_model

// >>> tb.sv
// Purpose: self-checking bench for the cycle bridge
// Assumes: processor inputs change on the falling core_clk edge
// Notes:   status held until ready so no phase tracking is needed here
`include "cycle_bridge_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, reset_n = 1'b0, cpu_mem_io = 1'b0, cpu_s0_n = 1'b1;
  logic cpu_s1_n = 1'b1, byte_high_enable_n = 1'b1, board16 = 1'b0, zws_req = 1'b0;
  logic [23:0] cpu_addr = 24'h000000;
  logic [7:0] cpu_lo_data_in = 8'h00, stall = 8'h00, cpu_lo_data_out, exp_lo_data_in;
  logic [6:0] local_upper_addr;
  logic processor_clock_out, expansion_bus_clock, sys_addr_latch_strobe, sys_addr_bit0;
  logic bus_addr_latch_enable, fast_upper_addr_latch, low_lane_buf_en_n;
  logic high_lane_buf_en_n, byte_swap_buf_en_n, data_xmit_recv_dir, cpu_lo_data_oe_n;
  logic mem_read_n, mem_write_n, io_read_n, io_write_n, cpu_ready_n, bus_command_state;
  logic slow_mode_active, memcs16_n, iocs16_n, zero_ws_n, io_ch_rdy;
  logic first_ok, hold_ok, prev_ale, started;
  logic [2:0] lanes;
  int err_total = 0, samples_checked = 0, cyc = 0;
  int cnt, cmd_at, n_ale, n_sys_addr_latch_strobe, n_fast_upper_addr_latch;
  assign lanes = {low_lane_buf_en_n, high_lane_buf_en_n, byte_swap_buf_en_n};
  cpu_expansion_bus_cycle_bridge u_cpu_expansion_bus_cycle_bridge (
    .core_clk, .reset_n, .cpu_addr, .cpu_mem_io, .cpu_s0_n, .cpu_s1_n,
    .byte_high_enable_n, .cpu_lo_data_in, .exp_lo_data_in, .memcs16_n, .iocs16_n,
    .zero_ws_n, .io_ch_rdy, .processor_clock_out, .expansion_bus_clock,
    .sys_addr_latch_strobe, .bus_addr_latch_enable, .fast_upper_addr_latch,
    .local_upper_addr, .sys_addr_bit0, .low_lane_buf_en_n, .high_lane_buf_en_n,
    .byte_swap_buf_en_n, .data_xmit_recv_dir, .cpu_lo_data_out, .cpu_lo_data_oe_n,
    .mem_read_n, .mem_write_n, .io_read_n, .io_write_n, .cpu_ready_n,
    .bus_command_state, .slow_mode_active);
  expansion_board_model u_expansion_board_model (
    .core_clk, .reset_n, .mem_read_n, .mem_write_n, .io_read_n, .io_write_n,
    .sys_addr_bit0, .board16, .zws_req, .stall, .exp_lo_data_in, .memcs16_n,
    .iocs16_n, .zero_ws_n, .io_ch_rdy);
  // ====================================================
  // shared tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // one processor cycle; returns at the falling edge where ready is seen
  task automatic run(input logic m, input logic w, input logic [23:0] a, input logic bh,
                     input logic [7:0] d);
    @(negedge core_clk);
    cpu_addr = a;
    cpu_mem_io = m;
    cpu_s1_n = w;
    cpu_s0_n = !w;
    byte_high_enable_n = bh;
    cpu_lo_data_in = d;
    {cnt, n_ale, n_sys_addr_latch_strobe, n_fast_upper_addr_latch} = '0;
    cmd_at = -1;
    {first_ok, hold_ok, prev_ale, started} = 4'b1100;
    for (int i = 0; i < 400 && cpu_ready_n !== 1'b0; i++) begin
      @(negedge core_clk);
      cnt += started;
      if (bus_addr_latch_enable === 1'b1 && !prev_ale) begin
        n_ale++;
        started = 1'b1;
      end
      prev_ale = bus_addr_latch_enable;
      n_sys_addr_latch_strobe += sys_addr_latch_strobe;
      n_fast_upper_addr_latch += fast_upper_addr_latch;
      if (bus_command_state === 1'b1 && n_ale == 1) begin
        if (fast_upper_addr_latch === 1'b1 && local_upper_addr !== a[23:17]) hold_ok = 0;
        cpu_addr[23:17] = ~a[23:17];
      end
      if (cmd_at < 0 && (mem_read_n & mem_write_n & io_read_n & io_write_n) === 1'b0)
        cmd_at = cnt;
      if (mem_write_n === 1'b0 && sys_addr_bit0 === 1'b0) first_ok &= (lanes === 3'b011);
    end
    chk("ready", 1'b0, cpu_ready_n);
    cpu_s0_n = 1'b1;
    cpu_s1_n = 1'b1;
  endtask
  // ====================================================
  // scenarios
  task automatic t_clock();
    int pc = 0;
    int bc = 0;
    logic p = processor_clock_out;
    logic b = expansion_bus_clock;
    repeat (8) begin
      @(negedge core_clk);
      pc += (processor_clock_out !== p);
      bc += (expansion_bus_clock !== b);
      p = processor_clock_out;
      b = expansion_bus_clock;
    end
    chk("cpu clock toggles", 8, pc);
    chk("bus clock toggles", 4, bc);
  endtask
  task automatic t_register();
    chk("slow after reset", 1'b1, slow_mode_active);
    run(1'b0, 1'b0, {8'h00, `BTC_IO_ADDR}, 1'b1, 8'h00);
    chk("ctrl reset", `BTC_RESET, cpu_lo_data_out);
    chk("ctrl read oe", 1'b0, cpu_lo_data_oe_n);
    run(1'b0, 1'b1, {8'h00, `BTC_IO_ADDR}, 1'b1, 8'h04);
    chk("bit2 set", 1'b0, slow_mode_active);
    run(1'b0, 1'b1, {8'h00, `BTC_IO_ADDR}, 1'b1, 8'h03);
    chk("bit2 clear", 1'b1, slow_mode_active);
    run(1'b0, 1'b0, {8'h00, `BTC_IO_ADDR}, 1'b1, 8'h00);
    chk("ctrl readback", 8'h03, cpu_lo_data_out);
  endtask
  task automatic t_waits();
    for (int w = 0; w < 4; w++) begin
      run(1'b0, 1'b1, {8'h00, `BTC_IO_ADDR}, 1'b1, {1'b0, w[1:0], w[1:0], 3'b000});
      board16 = 1'b0;
      run(1'b0, 1'b0, 24'h000300, 1'b1, 8'h00);
      chk("waits8", 5 + 4 * (`WAIT8_BASE + w), cnt);
      chk("io cmd delay", 4, cmd_at);
      chk("sys_addr_latch_strobe cycles", 2, n_sys_addr_latch_strobe);
      chk("fast_upper_addr_latch cycles", 4, n_fast_upper_addr_latch);
      chk("fast_upper_addr_latch hold", 1'b1, hold_ok);
      chk("upper flow", 7'h7F, local_upper_addr);
      chk("read dir", 1'b0, data_xmit_recv_dir);
      chk("low lane only", 3'b011, lanes);
      board16 = 1'b1;
      run(1'b1, 1'b0, 24'hA40000, 1'b0, 8'h00);
      chk("waits16", 5 + 4 * w, cnt);
      chk("mem cmd start", 2, cmd_at);
      chk("mem16 single", 1, n_ale);
      chk("wide lanes", 3'b001, lanes);
    end
  endtask
  task automatic t_conv();
    run(1'b0, 1'b1, {8'h00, `BTC_IO_ADDR}, 1'b1, 8'h00);
    run(1'b0, 1'b0, 24'h000300, 1'b0, 8'h00);
    chk("io16 single", 1, n_ale);
    board16 = 1'b0;
    run(1'b1, 1'b0, 24'hA40000, 1'b0, 8'h00);
    chk("conv read bytes", 2, n_ale);
    chk("held byte", 8'h4C, cpu_lo_data_out);
    chk("held oe", 1'b0, cpu_lo_data_oe_n);
    chk("read2 lanes", 3'b100, lanes);
    chk("second odd", 1'b1, sys_addr_bit0);
    chk("mem read strobe", 1'b0, mem_read_n);
    run(1'b1, 1'b1, 24'hA40000, 1'b0, 8'h5A);
    chk("write1 lanes", 1'b1, first_ok);
    chk("write2 lanes", 3'b100, lanes);
    chk("write dir", 1'b1, data_xmit_recv_dir);
    chk("mem write strobe", 1'b0, mem_write_n);
    run(1'b1, 1'b0, 24'hA40001, 1'b0, 8'h00);
    chk("odd lanes", 3'b100, lanes);
    chk("odd single", 1, n_ale);
    run(1'b0, 1'b1, 24'h000300, 1'b1, 8'h00);
    chk("io write strobe", 1'b0, io_write_n);
    chk("io write delay", 4, cmd_at);
  endtask
  task automatic t_stall();
    stall = 8'h1E;
    run(1'b0, 1'b0, 24'h000300, 1'b1, 8'h00);
    chk("held by board", 1'b1, cnt > 35);
    chk("end after release", 1'b1, cnt <= 43);
    stall = 8'h00;
  endtask
  task automatic t_zws();
    run(1'b0, 1'b1, {8'h00, `BTC_IO_ADDR}, 1'b1, 8'h60);
    zws_req = 1'b1;
    stall = 8'h28;
    run(1'b0, 1'b0, 24'h000300, 1'b1, 8'h00);
    chk("zero wait end", 5, cnt);
  endtask
  // ====================================================
  // clock, watchdog, sequence
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    repeat (20) @(negedge core_clk);
    reset_n = 1'b1;
    t_clock();
    t_register();
    t_waits();
    t_conv();
    t_stall();
    t_zws();
    summarize();
  end
endmodule // tb
